// ==== acp_cell_port.sv ====
// ATM cell port toward up to four PHY devices
`timescale 1ns/1ps
module acp_cell_port #(
    parameter int CELL_LEN = acp_pkg::CELL_STD,
    parameter int TICK_DIV = acp_pkg::TICK_DIV
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // PHY side
    input wire logic [acp_pkg::PHY_W-1:0] rxPhy,
    input wire logic rxCellAvail,
    input wire logic [acp_pkg::DATA_W-1:0] rxPhyData,
    output logic rxEnable_r,
    input wire logic [acp_pkg::PHY_W-1:0] txPhy,
    input wire logic txCellAvail,
    output logic txEnable_r,
    output logic [acp_pkg::DATA_W-1:0] txPhyData_r,
    output logic [acp_pkg::PHY_W-1:0] phySel_r,
    output logic cellStart_r,
    // Received bytes toward core
    output logic rxValid_r,
    output logic [acp_pkg::DATA_W-1:0] rxData_r,
    output logic rxSoc_r,
    output logic [acp_pkg::CONN_W-1:0] rxConn_r,
    // Transmit bytes from core
    input wire logic txValid,
    input wire logic [acp_pkg::DATA_W-1:0] txData,
    output logic txReady,
    input wire logic txCellQueued,
    // Pace scheduler tick
    output logic paceTick_r
);
    acp_pkg::acp_state_type st_r, st_nxt;
    logic [acp_pkg::LEN_W-1:0] cnt_r, cnt_nxt;
    logic [15:0] tick_r, tick_nxt;
    logic fifoValid, fifoReady;
    logic [acp_pkg::DATA_W-1:0] fifoData;
    logic rxEn_nxt, txEn_nxt, cs_nxt, rxV_nxt, soc_nxt, pt_nxt;
    logic [acp_pkg::PHY_W-1:0] sel_nxt;
    logic [acp_pkg::DATA_W-1:0] txD_nxt, rxD_nxt;
    logic [acp_pkg::CONN_W-1:0] conn_r, conn_nxt;
    logic [acp_pkg::LEN_W-1:0] cellLen;

    // Length clamp to 64 bytes, extra bytes are tag
    // expanded cells
    assign cellLen = (CELL_LEN > acp_pkg::CELL_MAX) ? acp_pkg::LEN_MAX
                   : 7'(CELL_LEN);

    // ------------------------------------------------------------------
    // Transmit staging FIFO
    // ------------------------------------------------------------------
    acp_fifo #(
        .WIDTH(acp_pkg::DATA_W),
        .DEPTH(acp_pkg::FIFO_DEPTH),
        .AW(3)
    ) uTxFifo (
        .clk(ref_clk),
        .rst(sys_rst),
        .ce(clkEn),
        .inValid(txValid),
        .inData(txData),
        .inReady(txReady),
        .outValid(fifoValid),
        .outData(fifoData),
        .outReady(fifoReady)
    );

    // ------------------------------------------------------------------
    // Cell arbiter and burst engine
    // ------------------------------------------------------------------
    // Tx may stall mid-cell if the core lets the FIFO run dry
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        rxEn_nxt = 1'b0;
        txEn_nxt = 1'b0;
        cs_nxt = 1'b0;
        rxV_nxt = 1'b0;
        soc_nxt = 1'b0;
        sel_nxt = phySel_r;
        txD_nxt = txPhyData_r;
        rxD_nxt = rxData_r;
        conn_nxt = conn_r;
        fifoReady = 1'b0;
        unique case (st_r)
            acp_pkg::ST_IDLE: begin
                if (rxCellAvail) begin
                    st_nxt = acp_pkg::ST_RX;
                    cnt_nxt = cellLen;
                    sel_nxt = rxPhy;
                    cs_nxt = 1'b1;
                    rxEn_nxt = 1'b1;
                    // connection index
                    // Index is the PHY id; larger tables live off chip
                    conn_nxt = '0;
                    conn_nxt[acp_pkg::PHY_W-1:0] = rxPhy;
                end else if (txCellAvail && txCellQueued && fifoValid) begin
                    st_nxt = acp_pkg::ST_TX;
                    cnt_nxt = cellLen;
                    sel_nxt = txPhy;
                    cs_nxt = 1'b1;
                end
            end
            acp_pkg::ST_RX: begin
                rxV_nxt = 1'b1;
                rxD_nxt = rxPhyData;
                soc_nxt = (cnt_r == cellLen);
                cnt_nxt = cnt_r - acp_pkg::LEN_ONE;
                rxEn_nxt = (cnt_r != acp_pkg::LEN_ONE);
                if (cnt_r == acp_pkg::LEN_ONE) begin
                    st_nxt = acp_pkg::ST_IDLE;
                end
            end
            acp_pkg::ST_TX: begin
                // byte path, tx yields between cells
                fifoReady = fifoValid;
                txEn_nxt = fifoValid;
                txD_nxt = fifoData;
                if (fifoValid) begin
                    cnt_nxt = cnt_r - acp_pkg::LEN_ONE;
                    if (cnt_r == acp_pkg::LEN_ONE) begin
                        st_nxt = acp_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                st_nxt = acp_pkg::ST_IDLE;
            end
        endcase
    end

    always_comb begin
        pt_nxt = 1'b0;
        tick_nxt = tick_r + acp_pkg::TICK_ONE;
        if (tick_r == 16'(TICK_DIV - 1)) begin
            tick_nxt = acp_pkg::TICK_ZERO;
            pt_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r <= acp_pkg::ST_IDLE;
            cnt_r <= acp_pkg::LEN_ZERO;
            tick_r <= acp_pkg::TICK_ZERO;
            rxEnable_r <= 1'b0;
            txEnable_r <= 1'b0;
            txPhyData_r <= '0;
            phySel_r <= '0;
            cellStart_r <= 1'b0;
            rxValid_r <= 1'b0;
            rxData_r <= '0;
            rxSoc_r <= 1'b0;
            conn_r <= '0;
            paceTick_r <= 1'b0;
        end else if (clkEn) begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
            rxEnable_r <= rxEn_nxt;
            txEnable_r <= txEn_nxt;
            txPhyData_r <= txD_nxt;
            phySel_r <= sel_nxt;
            cellStart_r <= cs_nxt;
            rxValid_r <= rxV_nxt;
            rxData_r <= rxD_nxt;
            rxSoc_r <= soc_nxt;
            conn_r <= conn_nxt;
            paceTick_r <= pt_nxt;
        end
    end

    assign rxConn_r = conn_r;
endmodule

// ==== acp_pkg.sv ====
// Constants and types for the ATM cell port
// ------------------------------------------------------------------
// Function
// - Eight-bit cell data path each direction
// - Handshake per cell, whole cell burst on receive
// - Drive two-bit PHY select field
// - Receive served before transmit
// - No receive loss; transmit throttled
// - Cells up to 64 bytes accepted
// - Dedicated timer ticks pace scheduler
// - Connection index taken from the two-bit PHY id
// ------------------------------------------------------------------
package acp_pkg;
    localparam int DATA_W = 8;
    localparam int PHY_W = 2;
    localparam int CELL_STD = 53;
    localparam int CELL_MAX = 64;
    localparam int LEN_W = 7;
    localparam int CONN_NUM = 32;
    localparam int CONN_W = 5;
    localparam int FIFO_DEPTH = 8;
    localparam int TICK_DIV = 40;
    localparam logic [6:0] LEN_STD = 7'h35;
    localparam logic [6:0] LEN_MAX = 7'h40;
    localparam logic [6:0] LEN_ZERO = 7'h00;
    localparam logic [6:0] LEN_ONE = 7'h01;
    localparam logic [15:0] TICK_ONE = 16'h0001;
    localparam logic [15:0] TICK_ZERO = 16'h0000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RX = 3'b010,
        ST_TX = 3'b100
    } acp_state_type;
endpackage

// ==== acp_fifo.sv ====
// Byte FIFO with valid/ready on both sides
`timescale 1ns/1ps
module acp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // Clock
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Fill side
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    // Drain side
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;
    logic rdy_r, rdy_nxt;

    always_comb begin
        push = inValid && (cnt_r != (AW+1)'(DEPTH));
        pop = outReady && (cnt_r != '0);
        mem_nxt = mem_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        if (push) begin
            mem_nxt[wp_r] = inData;
            wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
        end
        if (pop) begin
            rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
        end
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        // Ready from a flop so the core never sees a compare path
        rdy_nxt = (cnt_nxt != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b1;
        end else if (ce) begin
            mem_r <= mem_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    assign inReady = rdy_r;
    assign outValid = (cnt_r != '0);
    assign outData = mem_r[rp_r];
endmodule

// ==== acp_phy_model.sv ====
// PHY-side model for the ATM cell port
`timescale 1ns/1ps
module acp_phy_model #(parameter int LEN = 53) (
    // Control from bench
    input wire logic clk,
    input wire logic load,
    input wire logic [1:0] loadPhy,
    input wire logic [7:0] base,
    // Cell port
    input wire logic rxEnable_r,
    output logic rxCellAvail,
    output logic [1:0] rxPhy,
    output logic [7:0] rxPhyData,
    input wire logic txEnable_r,
    input wire logic [7:0] txPhyData_r,
    output logic [7:0] txCount,
    output logic [7:0] txBad
);
    logic have = 1'b0;
    logic [7:0] idx = 8'h00;
    initial begin
        txCount = 8'h00;
        txBad = 8'h00;
    end
    assign rxCellAvail = have;
    assign rxPhy = loadPhy;
    // Released line shows inverse of base+LEN; that is the last byte when base+LEN is 0x00 or 0x80
    // whole bytes only
    assign rxPhyData = have ? base + idx : ~(base + idx);
    always @(posedge clk) begin
        if (load) begin
            have <= 1'b1;
            idx <= 8'h00;
        end else if (rxEnable_r) begin
            idx <= idx + 8'h01;
            if (idx == 8'(LEN - 1)) have <= 1'b0;
        end
        if (txEnable_r) begin
            if (txPhyData_r !== txCount) txBad <= txBad + 8'h01;
            txCount <= txCount + 8'h01;
        end
    end
endmodule

// ==== acp_cell_port_chk.sv ====
// Concurrent checks on the ATM cell port
`timescale 1ns/1ps
module acp_cell_port_chk #(
    parameter int CELL_LEN = 53,
    parameter int TICK_DIV = 40
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [1:0] rxPhy,
    input wire logic rxCellAvail,
    input wire logic [1:0] txPhy,
    input wire logic txCellAvail,
    input wire logic txCellQueued,
    input wire logic rxEnable_r,
    input wire logic txEnable_r,
    input wire logic [1:0] phySel_r,
    input wire logic cellStart_r,
    input wire logic rxValid_r,
    input wire logic rxSoc_r,
    input wire logic [4:0] rxConn_r,
    input wire logic paceTick_r
);
    default clocking @(posedge ref_clk); endclocking
    // Bursts are clamped to the longest cell
    localparam int BURST = (CELL_LEN > acp_pkg::CELL_MAX) ? acp_pkg::CELL_MAX
        : CELL_LEN;
    // Frozen cycles cancel attempts in flight
    default disable iff (sys_rst || !clkEn);
    sequence burst_end;
        ##BURST $fell(rxEnable_r);
    endsequence
    rx_first_a: assert property (
        cellStart_r |-> rxEnable_r == $past(rxCellAvail)) else $error("bad dir");
    tx_gate_a: assert property (
        cellStart_r && !rxEnable_r |-> $past(txCellAvail && txCellQueued))
        else $error("tx start unqualified");
    rx_len_a: assert property (
        $rose(rxEnable_r) |-> burst_end) else $error("rx burst length");
    rx_hold_a: assert property (
        rxEnable_r && !cellStart_r |-> $past(rxEnable_r)) else $error("gap");
    phy_sel_a: assert property (
        cellStart_r && rxEnable_r |-> phySel_r == $past(rxPhy))
        else $error("select wrong");
    conn_idx_a: assert property (
        rxSoc_r |-> rxValid_r && rxConn_r[1:0] == phySel_r)
        else $error("conn wrong");
    dir_excl_a: assert property (
        txEnable_r |-> !rxEnable_r) else $error("both directions");
    tx_sel_a: assert property (
        cellStart_r && !rxEnable_r |-> phySel_r == $past(txPhy))
        else $error("tx select wrong");
    tick_period_a: assert property (
        paceTick_r && clkEn |=> !paceTick_r ##(TICK_DIV-1) paceTick_r)
        else $error("tick period");
endmodule
bind acp_cell_port acp_cell_port_chk #(.CELL_LEN(CELL_LEN),
    .TICK_DIV(TICK_DIV)) i_chk (.ref_clk, .sys_rst, .clkEn, .rxPhy,
    .rxCellAvail, .txPhy, .txCellAvail, .txCellQueued, .rxEnable_r,
    .txEnable_r, .phySel_r, .cellStart_r, .rxValid_r, .rxSoc_r, .rxConn_r,
    .paceTick_r);

// ==== tb_top.sv ====
// Self-checking bench for the ATM cell port
`timescale 1ns/1ps
module tb_top;
    // --------
    // Signals
    // --------
    localparam int LEN = 64;
    logic ref_clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, load = 1'b0;
    logic [1:0] loadPhy = 2'h0, rxPhy, txPhy = 2'h1, phySel_r;
    logic [7:0] base = 8'h00, rxPhyData, txPhyData_r, rxData_r, txCount;
    logic [7:0] txBad;
    logic [7:0] txData = 8'h00;
    logic rxCellAvail, rxEnable_r, txEnable_r, cellStart_r, rxValid_r;
    logic rxSoc_r, txReady, paceTick_r, txValid = 1'b0;
    logic txCellAvail = 1'b0, txCellQueued = 1'b0;
    logic [4:0] rxConn_r;
    int num_errors = 0, cmp_count = 0, cyc = 0, ticks = 0;
    // Rows: expected connection, PHY id, first byte
    logic [14:0] rows [4] = '{15'h00A5, 15'h053C, 15'h0AF0, 15'h0F01};
    acp_cell_port #(.CELL_LEN(LEN), .TICK_DIV(4)) i_dut (.ref_clk,
        .sys_rst, .clkEn, .rxPhy, .rxCellAvail, .rxPhyData, .rxEnable_r,
        .txPhy, .txCellAvail, .txEnable_r, .txPhyData_r, .phySel_r,
        .cellStart_r, .rxValid_r, .rxData_r, .rxSoc_r, .rxConn_r, .txValid,
        .txData, .txReady, .txCellQueued, .paceTick_r);
    acp_phy_model #(.LEN(LEN)) i_phy (.clk(ref_clk), .load, .loadPhy,
        .base, .rxEnable_r, .rxCellAvail, .rxPhy, .rxPhyData, .txEnable_r,
        .txPhyData_r, .txCount, .txBad);
    always #12.5 ref_clk = ~ref_clk;
    // Hang guard well above the longest sequence
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            test_done();
        end
    end
    // --------
    // Tasks
    // --------
    task check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Tight wait: a tx cell served first would overrun it
    task rx_cell(input logic [1:0] phy, input logic [7:0] b,
        input logic [4:0] conn);
        loadPhy <= phy;
        base <= b;
        load <= 1'b1;
        @(posedge ref_clk);
        load <= 1'b0;
        rx_take(b, conn);
    endtask
    task rx_take(input logic [7:0] b, input logic [4:0] conn);
        int n;
        n = 0;
        while (rxSoc_r !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            n++;
        end
        check(8'(rxConn_r), 8'(conn));
        for (int i = 0; i < LEN; i++) begin
            check(rxData_r, b + 8'(i));
            check(8'(rxValid_r), 8'h01);
            @(posedge ref_clk);
        end
        check(8'(rxValid_r), 8'h00);
    endtask
    task feed;
        int s;
        s = 0;
        txValid <= 1'b1;
        while (s < LEN) begin
            @(posedge ref_clk);
            if (txReady === 1'b1) begin
                s++;
                txData <= 8'(s);
            end
        end
        txValid <= 1'b0;
    endtask
    task test_done;
        $display("errors %0d checks %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // --------
    // Sequence
    // --------
    initial begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        check(8'(rxEnable_r), 8'h00);
        check(8'(txEnable_r), 8'h00);
        @(posedge ref_clk);
        foreach (rows[k]) rx_cell(rows[k][9:8], rows[k][7:0], rows[k][14:10]);
        repeat (8) begin
            @(posedge ref_clk);
            ticks = ticks + int'(paceTick_r);
        end
        check(8'(ticks), 8'h02);
        // Frozen port must leave a pending cell alone
        clkEn <= 1'b0;
        loadPhy <= 2'h1;
        base <= 8'h80;
        load <= 1'b1;
        @(posedge ref_clk);
        load <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check(8'(rxEnable_r), 8'h00);
        check(8'(cellStart_r), 8'h00);
        clkEn <= 1'b1;
        rx_take(8'h80, 5'h01);
        // Full FIFO and rx pending together: rx must win
        fork
            feed();
            begin
                repeat (12) @(posedge ref_clk);
                fork
                    rx_cell(2'h2, 8'h40, 5'h02);
                    begin
                        // Tx qualifies on the edge rx becomes visible
                        @(posedge ref_clk);
                        txCellQueued <= 1'b1;
                        txCellAvail <= 1'b1;
                    end
                join
            end
        join
        repeat (20) @(posedge ref_clk);
        check(txCount, 8'(LEN));
        check(txBad, 8'h00);
        check(8'(phySel_r), 8'h01);
        // Mid-run reset clears the held select
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check(8'(phySel_r), 8'h00);
        check(8'(txEnable_r), 8'h00);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        test_done();
    end
endmodule
